//--- tb/sfel_stack_mem.sv
// Stack memory model that answers frame unit accesses after a chosen delay
module sfel_stack_mem
    import sfel_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   memReq,
    input  wire logic                   memWrite,
    input  wire logic [SFEL_SEG_W-1:0]  memSegment,
    input  wire logic [SFEL_DATA_W-1:0] memAddr,
    input  wire logic [SFEL_DATA_W-1:0] memWrData,
    input  wire logic [3:0]             ackDelay,
    output logic                        memAck,
    output logic [SFEL_DATA_W-1:0]      memRdData,
    output logic [SFEL_SEG_W-1:0]       lastSeg
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [SFEL_DATA_W-1:0] mem [logic [SFEL_DATA_W-1:0]];
    logic [3:0]             waitCnt;

    // Read data outside an answer is inverted every cycle, so a sample one cycle late sees the complement of the old word
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
            memRdData <= 32'h0000_0000;
            lastSeg <= 16'h0000;
        end else if (memReq && !memAck && waitCnt >= ackDelay) begin
            memAck <= 1'b1;
            waitCnt <= 4'h0;
            lastSeg <= memSegment;
            if (memWrite) begin
                mem[memAddr] = memWrData;
                memRdData <= ~memRdData;
            end else begin
                memRdData <= mem.exists(memAddr) ? mem[memAddr] : ~memRdData;
            end
        end else begin
            memAck <= 1'b0;
            waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
            memRdData <= ~memRdData;
        end
    end
endmodule

//--- tb/stack_frame_enter_leave_unit_tb.sv
// Self-checking testbench for the stack frame create/release unit
module stack_frame_enter_leave_unit_tb
    import sfel_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk, rst, createReq, releaseReq, busy, done;
    logic [15:0] storageBytes, segWrData, segRdData, memSegment, lastSeg;
    logic [4:0]  nestLevel;
    logic [2:0]  regWrIdx, regRdIdx, segWrIdx, segRdIdx;
    logic [31:0] baseOfStorage, regWrData, regRdData, flagsWrData, flagsRegister;
    logic [31:0] ipWrData, instructionPointer, memAddr, memWrData, memRdData;
    logic        regWrEn, segWrEn, flagsWrEn, ipWrEn, memReq, memWrite, memAck;
    logic [3:0]  ackDelay;
    int          fails, checked;

    sfel_frame_unit sfel_frame_unit_inst (.core_clk(core_clk), .rst(rst), .createReq(createReq),
        .releaseReq(releaseReq), .storageBytes(storageBytes), .nestLevel(nestLevel), .busy(busy),
        .done(done), .baseOfStorage(baseOfStorage), .regWrEn(regWrEn), .regWrIdx(regWrIdx),
        .regWrData(regWrData), .regRdIdx(regRdIdx), .regRdData(regRdData), .segWrEn(segWrEn),
        .segWrIdx(segWrIdx), .segWrData(segWrData), .segRdIdx(segRdIdx), .segRdData(segRdData),
        .flagsWrEn(flagsWrEn), .flagsWrData(flagsWrData), .flagsRegister(flagsRegister),
        .ipWrEn(ipWrEn), .ipWrData(ipWrData), .instructionPointer(instructionPointer),
        .memReq(memReq), .memWrite(memWrite), .memSegment(memSegment), .memAddr(memAddr),
        .memWrData(memWrData), .memAck(memAck), .memRdData(memRdData));

    sfel_stack_mem sfel_stack_mem_inst (.core_clk(core_clk), .rst(rst), .memReq(memReq),
        .memWrite(memWrite), .memSegment(memSegment), .memAddr(memAddr), .memWrData(memWrData),
        .ackDelay(ackDelay), .memAck(memAck), .memRdData(memRdData), .lastSeg(lastSeg));

    always #4 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] idx, input logic [31:0] val);
        @(negedge core_clk);
        regWrEn = 1'b1;
        regWrIdx = idx;
        regWrData = val;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] idx, output logic [31:0] val);
        @(negedge core_clk);
        regRdIdx = idx;
        #1;
        val = regRdData;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (done !== 1'b1) begin
            fails++;
            $display("Error at %0t: no completion", $time);
            print_verdict();
        end
    endtask

    task automatic test_registers();
        logic [31:0] val;
        for (int i = 0; i < 8; i++) begin
            rd_reg(3'(i), val);
            cmp(val, SFEL_RST_GPR, "gpr reset");
            wr_reg(3'(i), 32'h1111_0000 + 32'(i));
            rd_reg(3'(i), val);
            cmp(val, 32'h1111_0000 + 32'(i), "gpr write");
        end
        for (int i = 0; i < 7; i++) begin
            @(negedge core_clk);
            segRdIdx = 3'(i);
            #1;
            cmp({16'h0000, segRdData}, {16'h0000, SFEL_RST_SEG}, "seg reset");
            segWrEn = 1'b1;
            segWrIdx = 3'(i);
            segWrData = 16'h0a00 + 16'(i);
            @(negedge core_clk);
            segWrEn = 1'b0;
            #1;
            cmp({16'h0000, segRdData}, (i < 6) ? 32'h0000_0a00 + 32'(i) : 32'h0, "seg write");
        end
        cmp(flagsRegister, SFEL_RST_FLAGS, "flags reset");
        cmp(instructionPointer, SFEL_RST_IP, "ip reset");
        @(negedge core_clk);
        flagsWrEn = 1'b1;
        flagsWrData = 32'h0000_0ad7;
        ipWrEn = 1'b1;
        ipWrData = 32'h0000_1234;
        @(negedge core_clk);
        flagsWrEn = 1'b0;
        ipWrEn = 1'b0;
        segRdIdx = SFEL_IDX_SS;
        cmp(flagsRegister, 32'h0000_0ad7, "flags write");
        cmp(instructionPointer, 32'h0000_1234, "ip write");
        $display("Test registers finished");
    endtask

    // Shared create step; a general register write is attempted while busy and must be lost
    task automatic do_create(input logic [31:0] sp, input logic [31:0] fp, input logic [15:0] stor,
                             input logic [4:0] lvl);
        logic [31:0] val;
        wr_reg(3'h4, sp);
        wr_reg(3'h5, fp);
        for (int i = 1; i < lvl; i++) sfel_stack_mem_inst.mem[fp - 4 * i] = 32'hd000_0000 + 32'(i);
        sfel_stack_mem_inst.mem[sp - 8] = 32'h5a5a_5a5a;
        @(negedge core_clk);
        createReq = 1'b1;
        storageBytes = stor;
        nestLevel = lvl;
        @(negedge core_clk);
        createReq = 1'b0;
        cmp({31'h0, busy}, 32'h1, "busy during create");
        regWrEn = 1'b1;
        regWrIdx = 3'h0;
        regWrData = 32'hdead_beef;
        @(negedge core_clk);
        regWrEn = 1'b0;
        wait_done();
        cmp({31'h0, busy}, 32'h0, "idle after create");
        cmp(sfel_stack_mem_inst.mem[sp - 4], fp, "saved frame pointer");
        for (int i = 1; i < lvl; i++)
            cmp(sfel_stack_mem_inst.mem[sp - 4 - 4 * i], 32'hd000_0000 + 32'(i), "copied pointer");
        if (lvl > 0) cmp(sfel_stack_mem_inst.mem[sp - 4 - 4 * lvl], sp - 4, "new frame ptr");
        else cmp(sfel_stack_mem_inst.mem[sp - 8], 32'h5a5a_5a5a, "no copy at level zero");
        rd_reg(SFEL_IDX_FP, val);
        cmp(val, sp - 4, "frame pointer");
        rd_reg(SFEL_IDX_SP, val);
        cmp(val, sp - 4 - 4 * lvl - 32'(stor), "stack pointer");
        cmp(baseOfStorage, sp, "storage base");
        cmp({16'h0000, lastSeg}, 32'h0000_0a02, "stack segment");
        rd_reg(3'h0, val);
        cmp(val, 32'h1111_0000, "write while busy");
    endtask

    task automatic test_outermost();
        ackDelay = 4'h0;
        do_create(32'h0000_1000, 32'h0000_abc0, 16'h0020, 5'h00);
        $display("Test level zero finished");
    endtask

    task automatic test_main_level();
        ackDelay = 4'h3;
        do_create(32'h0000_2000, 32'h0000_3000, 16'h000c, 5'h01);
        $display("Test level one finished");
    endtask

    task automatic test_nested_release();
        logic [31:0] val;
        ackDelay = 4'h1;
        do_create(32'h0000_4000, 32'h0000_5000, 16'h0800, 5'h03);
        @(negedge core_clk);
        releaseReq = 1'b1;
        @(negedge core_clk);
        releaseReq = 1'b0;
        wait_done();
        rd_reg(SFEL_IDX_FP, val);
        cmp(val, 32'h0000_5000, "restored frame pointer");
        rd_reg(SFEL_IDX_SP, val);
        cmp(val, 32'h0000_4000, "restored stack pointer");
        $display("Test nested create and release finished");
    endtask

    task automatic test_deepest();
        ackDelay = 4'h0;
        do_create(32'h0000_8000, 32'h0000_9000, 16'hffff, 5'h1f);
        $display("Test level thirty-one finished");
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {createReq, releaseReq, regWrEn, segWrEn, flagsWrEn, ipWrEn} = 6'h00;
        {storageBytes, segWrData, nestLevel, regWrIdx, regRdIdx, segWrIdx, segRdIdx} = 49'h0;
        {regWrData, flagsWrData, ipWrData} = 96'h0;
        ackDelay = 4'h0;
        fails = 0;
        checked = 0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        test_registers();
        test_outermost();
        test_main_level();
        test_nested_release();
        test_deepest();
        print_verdict();
    end
endmodule

//--- verilog/sfel_frame_unit.sv
// Stack frame create/release unit with its architectural registers
//
// Function
// - Outermost-level create reserves storage and copies no earlier frame pointers.
// - First display word written is the frame pointer held before the create.
// - Level-one frame's second display word equals the new frame pointer.
// - After create, frame pointer addresses first display word; stack pointer addresses frame end.
// - Deeper entry copies caller display pointers after saving caller frame pointer.
// - Level three from level two keeps the two copied pointers in order.
// - Same-level call copies enclosing pointers only, not the caller frame pointer.
// - Outermost dynamic storage base is display frame pointer plus four bytes.
// - Release first loads stack pointer from frame pointer.
// - Release then pops saved frame pointer, restoring the pre-create stack pointer.
// - Eight 32-bit general registers for address forming.
// - Six 16-bit segment registers for memory access.
// - A 32-bit flags register for status and control.
// - A 32-bit instruction pointer holds the current instruction address.
// - Create takes a nesting level operand from zero to thirty-one.
// - Level zero pushes frame pointer, copies stack pointer, subtracts storage.
// - After the display, stack pointer drops by the storage byte count.
module sfel_frame_unit
    import sfel_pkg::*;
#(
    parameter int STORE_W = SFEL_STORE_W
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   createReq,
    input  wire logic                   releaseReq,
    input  wire logic [STORE_W-1:0]     storageBytes,
    input  wire logic [SFEL_LEVEL_W-1:0] nestLevel,
    output logic                        busy,
    output logic                        done,
    output logic [SFEL_DATA_W-1:0]      baseOfStorage,
    input  wire logic                   regWrEn,
    input  wire logic [2:0]             regWrIdx,
    input  wire logic [SFEL_DATA_W-1:0] regWrData,
    input  wire logic [2:0]             regRdIdx,
    output logic [SFEL_DATA_W-1:0]      regRdData,
    input  wire logic                   segWrEn,
    input  wire logic [2:0]             segWrIdx,
    input  wire logic [SFEL_SEG_W-1:0]  segWrData,
    input  wire logic [2:0]             segRdIdx,
    output logic [SFEL_SEG_W-1:0]       segRdData,
    input  wire logic                   flagsWrEn,
    input  wire logic [SFEL_DATA_W-1:0] flagsWrData,
    output logic [SFEL_DATA_W-1:0]      flagsRegister,
    input  wire logic                   ipWrEn,
    input  wire logic [SFEL_DATA_W-1:0] ipWrData,
    output logic [SFEL_DATA_W-1:0]      instructionPointer,
    output logic                        memReq,
    output logic                        memWrite,
    output logic [SFEL_SEG_W-1:0]       memSegment,
    output logic [SFEL_DATA_W-1:0]      memAddr,
    output logic [SFEL_DATA_W-1:0]      memWrData,
    input  wire logic                   memAck,
    input  wire logic [SFEL_DATA_W-1:0] memRdData
);
    typedef struct packed {
        sfel_state_type                 state;
        logic [SFEL_DATA_W-1:0]         stackPointer;
        logic [SFEL_DATA_W-1:0]         framePointer;
        logic [SFEL_DATA_W-1:0]         framePtrTemp;
        logic [SFEL_DATA_W-1:0]         oldFramePtr;
        logic [STORE_W-1:0]             storage;
        logic [SFEL_LEVEL_W-1:0]        level;
        logic [SFEL_LEVEL_W-1:0]        copyIdx;
        logic [SFEL_DATA_W-1:0]         copyData;
        logic [SFEL_DATA_W-1:0]         flags;
        logic [SFEL_DATA_W-1:0]         ip;
        logic [SFEL_DATA_W-1:0]         storeBase;
        logic                           done;
    } sfel_core_type;

    sfel_core_type cur_r;
    sfel_core_type cur_nxt;

    logic [SFEL_DATA_W-1:0] gprRd;
    logic [SFEL_DATA_W-1:0] gprAll [SFEL_NUM_GPR];
    logic [SFEL_SEG_W-1:0]  segRd;
    logic [SFEL_SEG_W-1:0]  stackSeg;
    logic                   unitWrEn;
    logic [2:0]             unitWrIdx;
    logic [SFEL_DATA_W-1:0] unitWrData;

    // Frame and stack pointers live in the state struct; GPR slots 4 and 5 stay unused
    sfel_gpr_file #(.NUM_REGS(SFEL_NUM_GPR), .WIDTH(SFEL_DATA_W)) uGpr (
        .core_clk (core_clk),
        .rst      (rst),
        .wrEn     (unitWrEn),
        .wrIdx    (unitWrIdx),
        .wrData   (unitWrData),
        .rdIdx    (regRdIdx),
        .rdData   (gprRd),
        .allRegs  (gprAll)
    );

    sfel_seg_file #(.NUM_REGS(SFEL_NUM_SEG), .WIDTH(SFEL_SEG_W)) uSeg (
        .core_clk (core_clk),
        .rst      (rst),
        .wrEn     (segWrEn && !busy),
        .wrIdx    (segWrIdx),
        .wrData   (segWrData),
        .rdIdx    (segRdIdx),
        .rdData   (segRd)
    );

    // Stack segment read through a second decode of the same file would need a port; keep a shadow
    logic [SFEL_SEG_W-1:0] ssShadow_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ssShadow_r <= SFEL_RST_SEG;
        end else if (segWrEn && !busy && segWrIdx == SFEL_IDX_SS) begin
            ssShadow_r <= segWrData;
        end
    end
    assign stackSeg = ssShadow_r;

    // Host writes to SP/FP land in the struct, others in the file; blocked while busy
    assign unitWrEn   = regWrEn && !busy && regWrIdx != SFEL_IDX_SP && regWrIdx != SFEL_IDX_FP;
    assign unitWrIdx  = regWrIdx;
    assign unitWrData = regWrData;

    always_comb begin
        if (regRdIdx == SFEL_IDX_SP) begin
            regRdData = cur_r.stackPointer;
        end else if (regRdIdx == SFEL_IDX_FP) begin
            regRdData = cur_r.framePointer;
        end else begin
            regRdData = gprRd;
        end
    end

    assign segRdData          = segRd;
    assign flagsRegister      = cur_r.flags;
    assign instructionPointer = cur_r.ip;
    assign busy               = cur_r.state != SFEL_IDLE;
    assign done               = cur_r.done;
    assign baseOfStorage      = cur_r.storeBase;
    assign memSegment         = stackSeg;

    logic [SFEL_DATA_W-1:0] spDec;
    assign spDec = cur_r.stackPointer - SFEL_DWORD_BYTES;

    // Memory request outputs decoded from state
    always_comb begin
        memReq    = 1'b0;
        memWrite  = 1'b0;
        memAddr   = '0;
        memWrData = '0;
        case (cur_r.state)
            SFEL_PUSH_OLD: begin
                memReq    = 1'b1;
                memWrite  = 1'b1;
                memAddr   = spDec;
                memWrData = cur_r.framePointer;
            end
            SFEL_COPY_RD: begin
                memReq  = 1'b1;
                memAddr = cur_r.framePtrTemp;
            end
            SFEL_COPY_WR: begin
                memReq    = 1'b1;
                memWrite  = 1'b1;
                memAddr   = spDec;
                memWrData = cur_r.copyData;
            end
            SFEL_PUSH_NEW: begin
                memReq    = 1'b1;
                memWrite  = 1'b1;
                memAddr   = spDec;
                memWrData = cur_r.oldFramePtr;
            end
            SFEL_REL_RD: begin
                memReq  = 1'b1;
                memAddr = cur_r.stackPointer;
            end
            default: begin
                memReq = 1'b0;
            end
        endcase
    end

    always_comb begin
        cur_nxt      = cur_r;
        cur_nxt.done = 1'b0;
        if (flagsWrEn && cur_r.state == SFEL_IDLE) begin
            cur_nxt.flags = flagsWrData;
        end
        if (ipWrEn && cur_r.state == SFEL_IDLE) begin
            cur_nxt.ip = ipWrData;
        end
        case (cur_r.state)
            SFEL_IDLE: begin
                if (regWrEn && regWrIdx == SFEL_IDX_SP) begin
                    cur_nxt.stackPointer = regWrData;
                end else if (regWrEn && regWrIdx == SFEL_IDX_FP) begin
                    cur_nxt.framePointer = regWrData;
                end
                if (createReq) begin
                    cur_nxt.storage = storageBytes;
                    cur_nxt.level   = nestLevel;
                    cur_nxt.copyIdx = 5'h01;
                    cur_nxt.state   = SFEL_PUSH_OLD;
                end else if (releaseReq) begin
                    cur_nxt.stackPointer = cur_r.framePointer;
                    cur_nxt.state        = SFEL_REL_RD;
                end
            end
            SFEL_PUSH_OLD: begin
                if (memAck) begin
                    cur_nxt.stackPointer = spDec;
                    // Caller display starts one word below its saved pointer
                    cur_nxt.framePtrTemp = cur_r.framePointer - SFEL_DWORD_BYTES;
                    cur_nxt.oldFramePtr  = spDec;          // New frame pointer value
                    if (cur_r.level == '0) begin
                        cur_nxt.state = SFEL_ALLOC;
                    end else if (cur_r.level == 5'h01) begin
                        cur_nxt.state = SFEL_PUSH_NEW;
                    end else begin
                        cur_nxt.state = SFEL_COPY_RD;
                    end
                end
            end
            SFEL_COPY_RD: begin
                cur_nxt.framePtrTemp = cur_r.framePtrTemp - SFEL_DWORD_BYTES;
                cur_nxt.state        = SFEL_COPY_WAIT;
                if (memAck) begin
                    cur_nxt.copyData = memRdData;
                    cur_nxt.state    = SFEL_COPY_WR;
                end else begin
                    cur_nxt.framePtrTemp = cur_r.framePtrTemp;
                    cur_nxt.state        = SFEL_COPY_RD;
                end
            end
            SFEL_COPY_WR: begin
                if (memAck) begin
                    cur_nxt.stackPointer = spDec;
                    cur_nxt.copyIdx      = cur_r.copyIdx + 5'h01;
                    // Copies level-1 pointers; the caller's own pointer is added only one level deeper
                    if (cur_r.copyIdx + 5'h01 >= cur_r.level) begin
                        cur_nxt.state = SFEL_PUSH_NEW;
                    end else begin
                        cur_nxt.state = SFEL_COPY_RD;
                    end
                end
            end
            SFEL_PUSH_NEW: begin
                if (memAck) begin
                    cur_nxt.stackPointer = spDec;
                    cur_nxt.state        = SFEL_ALLOC;
                end
            end
            SFEL_ALLOC: begin
                cur_nxt.framePointer = cur_r.oldFramePtr;
                cur_nxt.stackPointer = cur_r.stackPointer - SFEL_DATA_W'(cur_r.storage);
                cur_nxt.storeBase    = cur_r.oldFramePtr + SFEL_DWORD_BYTES;
                cur_nxt.done         = 1'b1;
                cur_nxt.state        = SFEL_IDLE;
            end
            SFEL_REL_RD: begin
                if (memAck) begin
                    cur_nxt.framePointer = memRdData;
                    cur_nxt.stackPointer = cur_r.stackPointer + SFEL_DWORD_BYTES;
                    cur_nxt.done         = 1'b1;
                    cur_nxt.state        = SFEL_IDLE;
                end
            end
            default: begin
                cur_nxt.state = SFEL_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur_r              <= '0;
            cur_r.state        <= SFEL_IDLE;
            cur_r.flags        <= SFEL_RST_FLAGS;
            cur_r.ip           <= SFEL_RST_IP;
            cur_r.stackPointer <= SFEL_RST_GPR;
            cur_r.framePointer <= SFEL_RST_GPR;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Assertions
    sequence sCreateStart;
        cur_r.state == SFEL_IDLE && createReq;
    endsequence

    a_first_push_fp: assert property (@(posedge core_clk) disable iff (rst)
        sCreateStart |=> (memWrData == $past(cur_r.framePointer) && memWrite))
        else $error("first display word is not the old frame pointer");

    a_push_addr_dec: assert property (@(posedge core_clk) disable iff (rst)
        (memReq && memWrite) |-> memAddr == cur_r.stackPointer - 32'h4)
        else $error("display push not below stack pointer by four");

    a_level0_no_copy: assert property (@(posedge core_clk) disable iff (rst)
        (cur_r.state == SFEL_PUSH_OLD && memAck && cur_r.level == '0) |=> cur_r.state == SFEL_ALLOC)
        else $error("level zero create did not go straight to allocation");

    a_alloc_fp: assert property (@(posedge core_clk) disable iff (rst)
        cur_r.state == SFEL_ALLOC |=> (cur_r.framePointer == $past(cur_r.oldFramePtr) && done))
        else $error("frame pointer not set to first display word");

    a_alloc_sp: assert property (@(posedge core_clk) disable iff (rst)
        cur_r.state == SFEL_ALLOC |=> cur_r.stackPointer == $past(cur_r.stackPointer) - 32'($past(cur_r.storage)))
        else $error("storage not subtracted from stack pointer");

    a_store_base: assert property (@(posedge core_clk) disable iff (rst)
        cur_r.state == SFEL_ALLOC |=> cur_r.storeBase == cur_r.framePointer + 32'h4)
        else $error("storage base is not frame pointer plus four");

    a_release_sp: assert property (@(posedge core_clk) disable iff (rst)
        (cur_r.state == SFEL_IDLE && !createReq && releaseReq) |=> cur_r.stackPointer == $past(cur_r.framePointer))
        else $error("release did not load stack pointer from frame pointer");

    a_release_pop: assert property (@(posedge core_clk) disable iff (rst)
        (cur_r.state == SFEL_REL_RD && memAck) |=> (cur_r.framePointer == $past(memRdData) && done))
        else $error("release did not pop the saved frame pointer");

    a_copy_count: assert property (@(posedge core_clk) disable iff (rst)
        cur_r.state == SFEL_COPY_WR |-> cur_r.copyIdx < cur_r.level)
        else $error("display copy ran past the level count");

    a_stack_seg: assert property (@(posedge core_clk) disable iff (rst)
        (memReq && segRdIdx == SFEL_IDX_SS) |-> memSegment == segRd)
        else $error("stack access not through stack segment");
endmodule

//--- verilog/sfel_gpr_file.sv
// General register file with one read port, all-register outputs and one write port
module sfel_gpr_file
    import sfel_pkg::*;
#(
    parameter int NUM_REGS = SFEL_NUM_GPR,
    parameter int WIDTH    = SFEL_DATA_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        wrEn,
    input  wire logic [$clog2(NUM_REGS)-1:0] wrIdx,
    input  wire logic [WIDTH-1:0]            wrData,
    input  wire logic [$clog2(NUM_REGS)-1:0] rdIdx,
    output logic      [WIDTH-1:0]            rdData,
    output logic      [WIDTH-1:0]            allRegs [NUM_REGS]
);
    logic [WIDTH-1:0] regs_r [NUM_REGS];

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gReg
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    regs_r[g] <= WIDTH'(SFEL_RST_GPR);
                end else if (wrEn && wrIdx == g) begin
                    regs_r[g] <= wrData;
                end
            end
            assign allRegs[g] = regs_r[g];
        end
    endgenerate

    assign rdData = regs_r[rdIdx];
endmodule

//--- verilog/sfel_pkg.sv
// Package: constants and types for the stack frame create/release unit
package sfel_pkg;
    localparam int          SFEL_DATA_W     = 32;
    localparam int          SFEL_SEG_W      = 16;
    localparam int          SFEL_NUM_GPR    = 8;
    localparam int          SFEL_NUM_SEG    = 6;
    localparam int          SFEL_LEVEL_W    = 5;
    localparam int          SFEL_STORE_W    = 16;
    localparam logic [31:0] SFEL_DWORD_BYTES = 32'h0000_0004;
    localparam logic [2:0]  SFEL_IDX_SP     = 3'h4;
    localparam logic [2:0]  SFEL_IDX_FP     = 3'h5;
    localparam logic [2:0]  SFEL_IDX_SS     = 3'h2;
    localparam logic [31:0] SFEL_RST_GPR    = 32'h0000_0000;
    localparam logic [15:0] SFEL_RST_SEG    = 16'h0000;
    localparam logic [31:0] SFEL_RST_FLAGS  = 32'h0000_0002;
    localparam logic [31:0] SFEL_RST_IP     = 32'h0000_0000;

    typedef enum {
        SFEL_IDLE,
        SFEL_PUSH_OLD,
        SFEL_COPY_RD,
        SFEL_COPY_WAIT,
        SFEL_COPY_WR,
        SFEL_PUSH_NEW,
        SFEL_ALLOC,
        SFEL_REL_RD,
        SFEL_REL_WAIT
    } sfel_state_type;
endpackage

//--- verilog/sfel_seg_file.sv
// Segment register file
module sfel_seg_file
    import sfel_pkg::*;
#(
    parameter int NUM_REGS = SFEL_NUM_SEG,
    parameter int WIDTH    = SFEL_SEG_W
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               wrEn,
    input  wire logic [2:0]         wrIdx,
    input  wire logic [WIDTH-1:0]   wrData,
    input  wire logic [2:0]         rdIdx,
    output logic      [WIDTH-1:0]   rdData
);
    logic [WIDTH-1:0] seg_r [NUM_REGS];

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gSeg
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    seg_r[g] <= WIDTH'(SFEL_RST_SEG);
                end else if (wrEn && wrIdx == 3'(g)) begin
                    seg_r[g] <= wrData;
                end
            end
        end
    endgenerate

    assign rdData = (rdIdx < 3'(NUM_REGS)) ? seg_r[rdIdx] : '0;
endmodule
